// [pss_ext_host.sv]
// Model of the external processor on the parallel port strobes.
// Its tasks are called by the bench just after hclk edges.
`timescale 1ns/1ps
`default_nettype none
module pss_ext_host
(
   // Clock
   input wire logic       hclk,
   // Pins
   input wire logic [7:0] pin_lvl,
   output logic           cs_n,
   output logic           wr_n,
   output logic           rd_n,
   output logic [7:0]     data
);
   initial
   begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      data = 8'h00;
   end
   // A released bus shows the inverse byte, so a late sample never matches.
   task automatic wr(input logic [7:0] b, input int hold);
      @(posedge hclk);
      {cs_n, wr_n, data} <= {2'b00, b};
      repeat (hold) @(posedge hclk);
      {cs_n, wr_n, data} <= {2'b11, ~b};
      repeat (4) @(posedge hclk);
   endtask
   task automatic rd(output logic [7:0] b, input int hold);
      @(posedge hclk);
      {cs_n, rd_n} <= 2'b00;
      repeat (hold + 2) @(posedge hclk);
      b = pin_lvl;
      {cs_n, rd_n} <= 2'b11;
      repeat (4) @(posedge hclk);
   endtask
endmodule
`default_nettype wire

// [pss_pkg.sv]
// Constants, register map and carrier types of the parallel slave port.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit external data port.
//
// Behaviour
// - Input-full flag set while received byte unread.
// - Output-full flag holds until external read completes.
// - Overflow flag on write while input full.
// - Mode bit selects slave port or GPIO.
// - Low four control bits read zero.
`default_nettype none
package pss_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_IN_DATA  = 8'h04;
   localparam logic [7:0]  OFF_OUT_DATA = 8'h08;
   localparam logic [7:0]  OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0]  OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0]  OFF_GPIO_OUT = 8'h14;
   localparam logic [7:0]  OFF_GPIO_DIR = 8'h18;
   localparam logic [7:0]  OFF_GPIO_IN  = 8'h1C;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned BIT_IBF      = 7;
   localparam int unsigned BIT_OBF      = 6;
   localparam int unsigned BIT_OVF      = 5;
   localparam int unsigned BIT_MODE     = 4;
   localparam int unsigned IRQ_WR       = 0;
   localparam int unsigned IRQ_RD       = 1;
   localparam int unsigned IRQ_OVF      = 2;
   localparam int unsigned IRQ_W        = 3;
   localparam logic [7:0]  BYTE_RST     = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
   } pss_aphase_t;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } pss_strobe_t;

endpackage

`default_nettype wire

// [pss_strobe_detect.sv]
// Completion detector for the external chip-selected strobes.
// Assumes strobe and data inputs are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none

module pss_strobe_detect
(
   // Clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // Control and pins
   input  wire logic               enable,
   input  wire pss_pkg::pss_strobe_t strobe,
   input  wire logic [7:0]         data_in,
   // Results
   output logic                    wr_done,
   output logic                    rd_done,
   output logic                    rd_active,
   output logic [7:0]              wr_byte
);

   logic       wr_act;
   logic       wr_prev_r;
   logic       rd_prev_r;
   logic [7:0] byte_r;

   assign wr_act    = enable & ~strobe.cs_n & ~strobe.wr_n;
   assign rd_active = enable & ~strobe.cs_n & ~strobe.rd_n;

   // A strobe completes when it leaves its active state.
   assign wr_done = wr_prev_r & ~wr_act;
   assign rd_done = rd_prev_r & ~rd_active;
   // While the write strobe stands the byte is tracked, so the value
   // present in the last active cycle is the one handed over.
   assign wr_byte = byte_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_prev_r <= 1'b0;
         rd_prev_r <= 1'b0;
         byte_r    <= pss_pkg::BYTE_RST;
      end
      else
      begin
         wr_prev_r <= wr_act;
         rd_prev_r <= rd_active;
         if (wr_act)
            byte_r <= data_in;
      end
   end

endmodule

`default_nettype wire

// [pss_top.sv]
// Parallel slave port: AHB-Lite register slave, buffers, flags, pins.
// Assumes external strobes are synchronous to hclk and active low.
`timescale 1ns/1ps
`default_nettype none

module pss_top
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // External parallel port
   input  wire logic        port_cs_n,
   input  wire logic        port_wr_n,
   input  wire logic        port_rd_n,
   input  wire logic [7:0]  parallel_data_pins_in,
   output logic [7:0]       parallel_data_pins_out,
   output logic [7:0]       parallel_data_pins_oe,
   // Interrupt
   output logic             slave_port_irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pss_pkg::pss_aphase_t      ap_r;
   logic                      ibf_r;
   logic                      obf_r;
   logic                      ovf_r;
   logic                      mode_r;
   logic [7:0]                in_buf_r;
   logic [7:0]                out_buf_r;
   logic [pss_pkg::IRQ_W-1:0] irq_stat_r;
   logic [pss_pkg::IRQ_W-1:0] irq_mask_r;
   logic [7:0]                gpio_out_r;
   logic [7:0]                gpio_dir_r;
   logic [31:0]               hrdata_r;
   logic                      hready_r;
   logic [7:0]                pin_out_r;
   logic [7:0]                pin_oe_r;
   logic                      irq_r;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   pss_pkg::pss_aphase_t ap_nxt;
   logic                 accept;
   logic                 dwr;
   logic [7:0]           wb;
   logic                 we_ctrl;
   logic                 we_out;
   logic                 we_stat;
   logic                 we_mask;
   logic                 we_gout;
   logic                 we_gdir;
   logic                 rd_in_acc;
   logic [7:0]           ctrl_view;
   logic [31:0]          rdata_nxt;

   assign accept       = hsel & hready & (htrans == pss_pkg::HTRANS_NSEQ);
   assign ap_nxt.valid = accept;
   assign ap_nxt.write = hwrite;
   assign ap_nxt.addr  = haddr[pss_pkg::ADDR_W-1:0];

   assign dwr     = ap_r.valid & ap_r.write;
   assign wb      = hwdata[7:0];
   assign we_ctrl = dwr & (ap_r.addr == pss_pkg::OFF_CTRL);
   assign we_out  = dwr & (ap_r.addr == pss_pkg::OFF_OUT_DATA);
   assign we_stat = dwr & (ap_r.addr == pss_pkg::OFF_IRQ_STAT);
   assign we_mask = dwr & (ap_r.addr == pss_pkg::OFF_IRQ_MASK);
   assign we_gout = dwr & (ap_r.addr == pss_pkg::OFF_GPIO_OUT);
   assign we_gdir = dwr & (ap_r.addr == pss_pkg::OFF_GPIO_DIR);

   // Reading the input byte frees the buffer; the side effect is taken
   // with the address phase so it lines up with the returned data.
   assign rd_in_acc = accept & ~hwrite
                    & (haddr[pss_pkg::ADDR_W-1:0] == pss_pkg::OFF_IN_DATA);

   assign ctrl_view = {ibf_r, obf_r, ovf_r, mode_r, 4'h0};

   // Unmapped addresses read as zero and always answer OKAY.
   assign rdata_nxt =
      (!accept || hwrite) ? 32'h0000_0000 :
      (ap_nxt.addr == pss_pkg::OFF_CTRL)     ? {24'h00_0000, ctrl_view} :
      (ap_nxt.addr == pss_pkg::OFF_IN_DATA)  ? {24'h00_0000, in_buf_r} :
      (ap_nxt.addr == pss_pkg::OFF_OUT_DATA) ? {24'h00_0000, out_buf_r} :
      (ap_nxt.addr == pss_pkg::OFF_IRQ_STAT) ? {29'h0, irq_stat_r} :
      (ap_nxt.addr == pss_pkg::OFF_IRQ_MASK) ? {29'h0, irq_mask_r} :
      (ap_nxt.addr == pss_pkg::OFF_GPIO_OUT) ? {24'h00_0000, gpio_out_r} :
      (ap_nxt.addr == pss_pkg::OFF_GPIO_DIR) ? {24'h00_0000, gpio_dir_r} :
      (ap_nxt.addr == pss_pkg::OFF_GPIO_IN)
         ? {24'h00_0000, parallel_data_pins_in} : 32'h0000_0000;

   // ----------------------------------------------------------------
   // External strobes
   // ----------------------------------------------------------------
   pss_pkg::pss_strobe_t strobe;
   logic                 wr_done;
   logic                 rd_done;
   logic                 rd_active;
   logic [7:0]           wr_byte;

   assign strobe.cs_n = port_cs_n;
   assign strobe.wr_n = port_wr_n;
   assign strobe.rd_n = port_rd_n;

   pss_strobe_detect u_strobe
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .enable    (mode_r),
      .strobe    (strobe),
      .data_in   (parallel_data_pins_in),
      .wr_done   (wr_done),
      .rd_done   (rd_done),
      .rd_active (rd_active),
      .wr_byte   (wr_byte)
   );

   // ----------------------------------------------------------------
   // Flags and buffers
   // ----------------------------------------------------------------
   logic                      ovf_ev;
   logic                      take_byte;
   logic                      ibf_nxt;
   logic                      obf_nxt;
   logic                      ovf_nxt;
   logic [pss_pkg::IRQ_W-1:0] irq_ev;
   logic [pss_pkg::IRQ_W-1:0] stat_nxt;

   // A byte arriving over an unread one is dropped; the old byte stays.
   assign ovf_ev    = wr_done & ibf_r;
   assign take_byte = wr_done & ~ibf_r;

   // Hardware set wins over a same-cycle software read.
   assign ibf_nxt = wr_done ? 1'b1 :
                    (rd_in_acc ? 1'b0 : ibf_r);
   // A new word from the CPU outranks a read that completes with it.
   assign obf_nxt = we_out ? 1'b1 :
                    (rd_done ? 1'b0 : obf_r);
   // Only software clears the overflow; a new event beats the clear.
   assign ovf_nxt = ovf_ev ? 1'b1 :
                    (we_ctrl ? wb[pss_pkg::BIT_OVF] : ovf_r);

   assign irq_ev[pss_pkg::IRQ_WR]  = wr_done;
   assign irq_ev[pss_pkg::IRQ_RD]  = rd_done;
   assign irq_ev[pss_pkg::IRQ_OVF] = ovf_ev;
   assign stat_nxt = (irq_stat_r & ~(we_stat ? wb[pss_pkg::IRQ_W-1:0]
                                             : pss_pkg::IRQ_RST))
                   | irq_ev;

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   logic [7:0] pin_out_nxt;
   logic [7:0] pin_oe_nxt;

   assign pin_out_nxt = mode_r ? out_buf_r : gpio_out_r;
   assign pin_oe_nxt  = mode_r ? {8{rd_active}} : gpio_dir_r;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_r       <= '0;
         hrdata_r   <= 32'h0000_0000;
         hready_r   <= 1'b0;
         ibf_r      <= 1'b0;
         obf_r      <= 1'b0;
         ovf_r      <= 1'b0;
         mode_r     <= 1'b0;
         irq_stat_r <= pss_pkg::IRQ_RST;
         irq_mask_r <= pss_pkg::IRQ_RST;
         irq_r      <= 1'b0;
      end
      else
      begin
         ap_r       <= ap_nxt;
         hrdata_r   <= rdata_nxt;
         hready_r   <= 1'b1;
         ibf_r      <= ibf_nxt;
         obf_r      <= obf_nxt;
         ovf_r      <= ovf_nxt;
         irq_stat_r <= stat_nxt;
         irq_r      <= |(stat_nxt & irq_mask_r);
         if (we_ctrl)
            mode_r <= wb[pss_pkg::BIT_MODE];
         if (we_mask)
            irq_mask_r <= wb[pss_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_buf_r   <= pss_pkg::BYTE_RST;
         out_buf_r  <= pss_pkg::BYTE_RST;
         gpio_out_r <= pss_pkg::BYTE_RST;
         gpio_dir_r <= pss_pkg::BYTE_RST;
         pin_out_r  <= pss_pkg::BYTE_RST;
         pin_oe_r   <= pss_pkg::BYTE_RST;
      end
      else
      begin
         pin_out_r <= pin_out_nxt;
         pin_oe_r  <= pin_oe_nxt;
         if (take_byte)
            in_buf_r <= wr_byte;
         if (we_out)
            out_buf_r <= wb;
         if (we_gout)
            gpio_out_r <= wb;
         if (we_gdir)
            gpio_dir_r <= wb;
      end
   end

   assign hrdata                 = hrdata_r;
   assign hreadyout              = hready_r;
   assign hresp                  = 1'b0;
   assign parallel_data_pins_out = pin_out_r;
   assign parallel_data_pins_oe  = pin_oe_r;
   assign slave_port_irq         = irq_r;

endmodule

`default_nettype wire

// [pss_top_sva.sv]
// Checker of the bus and pin timing of pss_top, bound at the file foot.
// Assumes hready is tied to hreadyout and hsel is held high.
`timescale 1ns/1ps
`default_nettype none
module pss_chk
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   // Pins
   input wire logic        port_cs_n,
   input wire logic        port_rd_n,
   input wire logic [7:0]  parallel_data_pins_oe
);
   // The mode bit is shadowed from bus writes, as no port shows it.
   logic       av_r;
   logic       aw_r;
   logic       mode_r;
   logic [7:0] aa_r;
   wire        rd_act = !port_cs_n && !port_rd_n;
   wire        rd_dp  = av_r && !aw_r;
   wire        ctl_dp = rd_dp && aa_r == pss_pkg::OFF_CTRL;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         av_r   <= 1'b0;
         aw_r   <= 1'b0;
         aa_r   <= 8'h00;
         mode_r <= 1'b0;
      end
      else
      begin
         if (av_r && aw_r && aa_r == pss_pkg::OFF_CTRL)
            mode_r <= hwdata[pss_pkg::BIT_MODE];
         av_r <= hready && htrans == pss_pkg::HTRANS_NSEQ;
         aw_r <= hwrite;
         aa_r <= haddr[7:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_up:
   assert property ($past(hresetn) |-> hreadyout) else $error("not ready");
   a_idle_zero:
   assert property (!rd_dp |-> hrdata == 32'h0) else $error("stray data");
   a_ctrl_spare:
   assert property (ctl_dp |-> hrdata[31:8] == 24'h0 && hrdata[3:0] == 4'h0)
      else $error("spare bits set");
   a_ctrl_mode:
   assert property (ctl_dp |-> hrdata[pss_pkg::BIT_MODE] == mode_r)
      else $error("mode bit wrong");
   a_gpio_ignore:
   assert property ((!mode_r && rd_act) [*2] |-> $stable(parallel_data_pins_oe))
      else $error("strobe acted in gpio mode");
   a_read_drive:
   assert property ((mode_r && rd_act) [*3] |-> parallel_data_pins_oe == 8'hFF)
      else $error("no drive on read");
endmodule
bind pss_top pss_chk u_chk (.hclk(hclk), .hresetn(hresetn), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .port_cs_n(port_cs_n),
   .port_rd_n(port_rd_n), .parallel_data_pins_oe(parallel_data_pins_oe));
`default_nettype wire

// [tb_parallel_slave_port_status.sv]
// Self-checking bench of pss_top with an LFSR-driven random part.
// Acts as AHB-Lite master itself and drives the pins via pss_ext_host.
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_slave_port_status;
   logic        hclk, hresetn, hwrite, hresp, hreadyout, irq;
   logic        cs_n, wr_n, rd_n, ov;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  hdat, pout, poe, rnd, v;
   int          fail_count, n_checks;
   wire  [7:0]  pin = (poe & pout) | (~poe & hdat);
   pss_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .port_cs_n(cs_n), .port_wr_n(wr_n), .port_rd_n(rd_n),
      .parallel_data_pins_in(pin), .parallel_data_pins_out(pout),
      .parallel_data_pins_oe(poe), .slave_port_irq(irq));
   pss_ext_host u_host (.hclk(hclk), .pin_lvl(pin), .cs_n(cs_n),
      .wr_n(wr_n), .rd_n(rd_n), .data(hdat));
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic [31:0] ctrl(input logic [3:0] f);
      return {24'h0, f, 4'h0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic print_verdict(input logic to);
      if (to)
         fail_count++;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus_wait;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
         @(posedge hclk);
         n++;
      end
      if (hreadyout !== 1'b1)
         print_verdict(1'b1);
   endtask
   // A read compares the word taken at the end of its data phase with d.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      haddr  <= {24'h0, a};
      htrans <= pss_pkg::HTRANS_NSEQ;
      hwrite <= w;
      bus_wait;
      htrans <= 2'h0;
      hwdata <= d;
      bus_wait;
      if (!w)
         chk($sformatf("reg %h", a), hrdata, d);
   endtask
   initial
   begin
      {hresetn, hwrite, htrans, haddr, hwdata} = '0;
      fail_count = 0;
      n_checks = 0;
      rnd = 8'h0E;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      xfer(1'b0, pss_pkg::OFF_CTRL, ctrl(4'h0));
      xfer(1'b0, 8'h40, 32'h0);
      rnd = lfsr(rnd);
      xfer(1'b1, pss_pkg::OFF_GPIO_DIR, 32'hFF);
      xfer(1'b1, pss_pkg::OFF_GPIO_OUT, {24'h0, rnd});
      repeat (2) @(posedge hclk);
      chk("gpio pins", {16'h0, poe, pout}, {16'h0, 8'hFF, rnd});
      xfer(1'b1, pss_pkg::OFF_GPIO_DIR, 32'h0);
      u_host.wr(rnd, 1);
      u_host.rd(v, 1);
      chk("gpio level", {24'h0, v}, {24'h0, ~rnd});
      xfer(1'b0, pss_pkg::OFF_GPIO_IN, {24'h0, ~rnd});
      xfer(1'b0, pss_pkg::OFF_CTRL, ctrl(4'h0));
      xfer(1'b0, pss_pkg::OFF_IRQ_STAT, 32'h0);
      xfer(1'b1, pss_pkg::OFF_CTRL, 32'hFF);
      xfer(1'b0, pss_pkg::OFF_CTRL, ctrl(4'h3));
      xfer(1'b1, pss_pkg::OFF_CTRL, 32'h1F);
      xfer(1'b0, pss_pkg::OFF_CTRL, ctrl(4'h1));
      xfer(1'b1, pss_pkg::OFF_IRQ_MASK, 32'h7);
      for (int i = 0; i < 6; i++)
      begin
         rnd = lfsr(rnd);
         ov = i[0];
         u_host.wr(rnd, 1 + i % 3);
         chk("irq up", {31'h0, irq}, 32'h1);
         if (ov)
            u_host.wr(~rnd, 2);
         xfer(1'b0, pss_pkg::OFF_CTRL, ctrl({2'b10, ov, 1'b1}));
         xfer(1'b0, pss_pkg::OFF_IN_DATA, {24'h0, rnd});
         xfer(1'b0, pss_pkg::OFF_CTRL, ctrl({2'b00, ov, 1'b1}));
         xfer(1'b0, pss_pkg::OFF_IRQ_STAT, {29'h0, ov, 2'h1});
         xfer(1'b1, pss_pkg::OFF_IRQ_STAT, 32'h7);
         xfer(1'b1, pss_pkg::OFF_CTRL, 32'h10);
      end
      xfer(1'b1, pss_pkg::OFF_IRQ_MASK, 32'h0);
      u_host.wr(rnd, 2);
      chk("irq masked", {31'h0, irq}, 32'h0);
      xfer(1'b0, pss_pkg::OFF_IN_DATA, {24'h0, rnd});
      rnd = lfsr(rnd);
      xfer(1'b1, pss_pkg::OFF_OUT_DATA, {24'h0, rnd});
      xfer(1'b0, pss_pkg::OFF_CTRL, ctrl(4'h5));
      u_host.rd(v, 3);
      chk("ext read", {24'h0, v}, {24'h0, rnd});
      xfer(1'b0, pss_pkg::OFF_CTRL, ctrl(4'h1));
      xfer(1'b0, pss_pkg::OFF_IRQ_STAT, 32'h3);
      chk("hresp okay", {31'h0, hresp}, 32'h0);
      print_verdict(1'b0);
   end
endmodule
`default_nettype wire
